// file: common/sotrip_defs.svh
// constants for the stub overcurrent trip block
`ifndef SOTRIP_DEFS_SVH
`define SOTRIP_DEFS_SVH

// register byte offsets
`define SOT_OFS_CTRL       12'h000
`define SOT_OFS_THRESH     12'h004
`define SOT_OFS_DELAY      12'h008
`define SOT_OFS_STATUS     12'h00c
`define SOT_OFS_IRQ_STAT   12'h010
`define SOT_OFS_IRQ_EN     12'h014
`define SOT_OFS_IRQ_CLR    12'h018

// control fields
`define SOT_CTRL_OP_BIT    0

// reset values
`define SOT_RST_OP         1'b0
`define SOT_RST_THRESH_PCT 9'd50
`define SOT_RST_DELAY_MS   16'd100

// setting limits
`define SOT_THRESH_MIN_PCT 9'd10
`define SOT_THRESH_MAX_PCT 9'd400
`define SOT_DELAY_MAX_MS   16'd60000

// timing: 1 ms tick at 20 MHz
`define SOT_CLK_HZ         20000000
`define SOT_TICK_NS        1000000
`define SOT_CLK_NS         50
`define SOT_CYC_PER_MS     (`SOT_TICK_NS / `SOT_CLK_NS)

// interrupt bits
`define SOT_IRQ_START      0
`define SOT_IRQ_TRIP       1
`define SOT_IRQ_W          2

`endif

// file: common/sotrip_pkg.sv
// types for the stub overcurrent trip block
package sotrip_pkg;
    typedef enum logic [1:0] {
        SOT_IDLE  = 2'b00,
        SOT_TIMING = 2'b01,
        SOT_TRIP  = 2'b11
    } sotrip_state_e;

    typedef enum logic [1:0] {
        SOT_AXI_RESP_OKAY   = 2'b00,
        SOT_AXI_RESP_SLVERR = 2'b10
    } sotrip_resp_e;
endpackage : sotrip_pkg

// file: hw/sotrip_top.sv
// stub overcurrent trip logic with axi4-lite settings access
//
// Summary of operation
// - decide from fundamental magnitudes and binary inputs
// - phase starts when magnitude exceeds percent threshold
// - one start flag per phase
// - general start is or of phases
// - start plus activate runs delay, then trip
// - trip only after delay timer expires
// - disable input suppresses starts and trip
// - operation setting off or on, default off
// - delay 0 to 60000 ms, default 100
`timescale 1ns/1ps
`default_nettype none
`include "sotrip_defs.svh"

module sotrip_top
    import sotrip_pkg::*;
#(
    parameter int MAG_W       = 16,
    parameter int CYC_PER_MS  = `SOT_CYC_PER_MS
)(
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // fundamental magnitudes, one per phase, same clock domain
    input  wire logic [MAG_W-1:0] phase1_mag,
    input  wire logic [MAG_W-1:0] phase2_mag,
    input  wire logic [MAG_W-1:0] phase3_mag,
    input  wire logic [MAG_W-1:0] nominal_mag,
    // binary status pins
    input  wire logic             function_disable_in,
    input  wire logic             breaker_open_in,
    // protection outputs
    output logic                  phase1_start_flag,
    output logic                  phase2_start_flag,
    output logic                  phase3_start_flag,
    output logic                  any_phase_start,
    output logic                  stub_trip_out,
    output logic                  irq,
    // axi4-lite slave
    input  wire logic [11:0]      s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire logic [11:0]      s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready
);

    // refuse parameter values that the datapath widths cannot serve
    if (MAG_W < 8 || MAG_W > 22 || CYC_PER_MS < 1 || CYC_PER_MS > 65535)
    begin : g_bad_params
        $error("sotrip_top: unsupported parameter values");
    end

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [1:0] dis_sync_q, dis_sync_d;
    logic [1:0] open_sync_q, open_sync_d;

    // two-stage synchronisers for the status pins
    always_comb
    begin
        dis_sync_d  = {dis_sync_q[0], function_disable_in};
        open_sync_d = {open_sync_q[0], breaker_open_in};
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            dis_sync_q  <= 2'b00;
            open_sync_q <= 2'b00;
        end
        else
        begin
            dis_sync_q  <= dis_sync_d;
            open_sync_q <= open_sync_d;
        end
    end

    // ----------------------------------------------------------------
    // settings registers
    // ----------------------------------------------------------------
    logic        op_on_q, op_on_d;
    logic [8:0]  thresh_q, thresh_d;
    logic [15:0] delay_q, delay_d;
    logic [`SOT_IRQ_W-1:0] irq_stat_q, irq_stat_d;
    logic [`SOT_IRQ_W-1:0] irq_en_q, irq_en_d;

    // ----------------------------------------------------------------
    // start detection
    // ----------------------------------------------------------------
    logic [2:0]       start_raw;
    logic [MAG_W-1:0] mag [3];
    logic             enabled;
    logic [MAG_W+8:0] lim_scaled;

    assign mag[0]     = phase1_mag;
    assign mag[1]     = phase2_mag;
    assign mag[2]     = phase3_mag;
    assign enabled    = op_on_q && !dis_sync_q[1];
    assign lim_scaled = (MAG_W+9)'(nominal_mag) * (MAG_W+9)'(thresh_q);

    // per-phase compare: mag*100 > nominal*pct
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_phase
            logic [MAG_W+8:0] mag_scaled;
            assign mag_scaled   = (MAG_W+9)'(mag[g]) * (MAG_W+9)'(100);
            assign start_raw[g] = enabled && (mag_scaled > lim_scaled);
        end
    endgenerate

    // ----------------------------------------------------------------
    // definite-time delay and trip
    // ----------------------------------------------------------------
    sotrip_state_e st_q, st_d;
    logic [15:0]   ms_q, ms_d;
    logic [15:0]   tick_q, tick_d;
    logic          any_raw, arm;
    logic [2:0]    start_d;
    logic          gen_d, trip_d;

    assign any_raw = |start_raw;
    assign arm     = any_raw && open_sync_q[1];

    // delay timer, counting whole milliseconds of armed time
    always_comb
    begin
        st_d   = st_q;
        ms_d   = ms_q;
        tick_d = tick_q;
        unique case (st_q)
            SOT_IDLE:
            begin
                ms_d   = 16'h0000;
                tick_d = 16'h0000;
                if (arm)
                    st_d = (delay_q == 16'h0000) ? SOT_TRIP : SOT_TIMING;
            end
            SOT_TIMING:
            begin
                if (!arm)
                    st_d = SOT_IDLE;
                else if (tick_q == 16'(CYC_PER_MS - 1))
                begin
                    tick_d = 16'h0000;
                    ms_d   = ms_q + 16'h0001;
                    if (ms_q + 16'h0001 >= delay_q)
                        st_d = SOT_TRIP;
                end
                else
                    tick_d = tick_q + 16'h0001;
            end
            SOT_TRIP:
            begin
                if (!arm)
                    st_d = SOT_IDLE;
            end
            default: st_d = SOT_IDLE;
        endcase
        start_d = start_raw;
        gen_d   = any_raw;
        trip_d  = (st_d == SOT_TRIP);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_q              <= SOT_IDLE;
            ms_q              <= 16'h0000;
            tick_q            <= 16'h0000;
            phase1_start_flag <= 1'b0;
            phase2_start_flag <= 1'b0;
            phase3_start_flag <= 1'b0;
            any_phase_start   <= 1'b0;
            stub_trip_out     <= 1'b0;
        end
        else
        begin
            st_q              <= st_d;
            ms_q              <= ms_d;
            tick_q            <= tick_d;
            phase1_start_flag <= start_d[0];
            phase2_start_flag <= start_d[1];
            phase3_start_flag <= start_d[2];
            any_phase_start   <= gen_d;
            stub_trip_out     <= trip_d;
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite slave
    // ----------------------------------------------------------------
    logic        aw_have_q, aw_have_d;
    logic        w_have_q, w_have_d;
    logic [11:0] aw_addr_q, aw_addr_d;
    logic [31:0] w_data_q, w_data_d;
    logic [3:0]  w_strb_q, w_strb_d;
    logic        bvalid_q, bvalid_d;
    logic [1:0]  bresp_q, bresp_d;
    logic        rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0]  rresp_q, rresp_d;
    logic        do_wr;
    logic [31:0] wmask, wr_val, rd_val;
    logic        wr_ok, rd_ok, trip_rise, start_rise;
    logic        awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;

    assign do_wr = aw_have_q && w_have_q && !bvalid_q;
    assign wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

    // irq events: rising start and rising trip
    assign start_rise = gen_d && !any_phase_start;
    assign trip_rise  = trip_d && !stub_trip_out;

    // write path, settings and interrupt registers
    always_comb
    begin
        aw_have_d  = aw_have_q;
        w_have_d   = w_have_q;
        aw_addr_d  = aw_addr_q;
        w_data_d   = w_data_q;
        w_strb_d   = w_strb_q;
        bvalid_d   = bvalid_q;
        bresp_d    = bresp_q;
        op_on_d    = op_on_q;
        thresh_d   = thresh_q;
        delay_d    = delay_q;
        irq_en_d   = irq_en_q;
        irq_stat_d = irq_stat_q;
        wr_ok      = 1'b0;
        wr_val     = 32'h0000_0000;
        if (s_axi_awvalid && !aw_have_q)
        begin
            aw_have_d = 1'b1;
            aw_addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_have_q)
        begin
            w_have_d = 1'b1;
            w_data_d = s_axi_wdata;
            w_strb_d = s_axi_wstrb;
        end
        if (do_wr)
        begin
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bvalid_d  = 1'b1;
            wr_ok     = 1'b1;
            unique case (aw_addr_q)
                `SOT_OFS_CTRL:
                begin
                    wr_val  = ({31'h0, op_on_q} & ~wmask) | (w_data_q & wmask);
                    op_on_d = wr_val[`SOT_CTRL_OP_BIT];
                end
                `SOT_OFS_THRESH:
                begin
                    wr_val = ({23'h0, thresh_q} & ~wmask) | (w_data_q & wmask);
                    if (wr_val[8:0] >= `SOT_THRESH_MIN_PCT
                        && wr_val[8:0] <= `SOT_THRESH_MAX_PCT && wr_val[31:9] == 23'h0)
                        thresh_d = wr_val[8:0];
                    else
                        wr_ok = 1'b0;
                end
                `SOT_OFS_DELAY:
                begin
                    wr_val = ({16'h0, delay_q} & ~wmask) | (w_data_q & wmask);
                    if (wr_val[15:0] <= `SOT_DELAY_MAX_MS && wr_val[31:16] == 16'h0)
                        delay_d = wr_val[15:0];
                    else
                        wr_ok = 1'b0;
                end
                `SOT_OFS_IRQ_EN:  irq_en_d = w_data_q[`SOT_IRQ_W-1:0] & wmask[`SOT_IRQ_W-1:0];
                `SOT_OFS_IRQ_CLR: irq_stat_d = irq_stat_q & ~(w_data_q[`SOT_IRQ_W-1:0]
                                                              & wmask[`SOT_IRQ_W-1:0]);
                default:          wr_ok = 1'b0;
            endcase
            bresp_d = wr_ok ? SOT_AXI_RESP_OKAY : SOT_AXI_RESP_SLVERR;
        end
        else if (bvalid_q && s_axi_bready)
            bvalid_d = 1'b0;
        // set wins over a clear in the same cycle
        irq_stat_d[`SOT_IRQ_START] = irq_stat_d[`SOT_IRQ_START] | start_rise;
        irq_stat_d[`SOT_IRQ_TRIP]  = irq_stat_d[`SOT_IRQ_TRIP] | trip_rise;
        // ready flags are registered so the bus sees flip-flop outputs
        awready_d = !aw_have_d;
        wready_d  = !w_have_d;
    end

    // read path
    always_comb
    begin
        rvalid_d = rvalid_q;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        rd_ok    = 1'b1;
        rd_val   = 32'h0000_0000;
        unique case (s_axi_araddr)
            `SOT_OFS_CTRL:     rd_val = {31'h0, op_on_q};
            `SOT_OFS_THRESH:   rd_val = {23'h0, thresh_q};
            `SOT_OFS_DELAY:    rd_val = {16'h0, delay_q};
            `SOT_OFS_STATUS:   rd_val = {26'h0, dis_sync_q[1], open_sync_q[1], stub_trip_out,
                                         phase3_start_flag, phase2_start_flag,
                                         phase1_start_flag};
            `SOT_OFS_IRQ_STAT: rd_val = {30'h0, irq_stat_q};
            `SOT_OFS_IRQ_EN:   rd_val = {30'h0, irq_en_q};
            `SOT_OFS_IRQ_CLR:  rd_val = 32'h0000_0000;
            default:           rd_ok  = 1'b0;
        endcase
        if (s_axi_arvalid && !rvalid_q)
        begin
            rvalid_d = 1'b1;
            rdata_d  = rd_val;
            rresp_d  = rd_ok ? SOT_AXI_RESP_OKAY : SOT_AXI_RESP_SLVERR;
        end
        else if (rvalid_q && s_axi_rready)
            rvalid_d = 1'b0;
        arready_d = !rvalid_d;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_q  <= 1'b0;
            w_have_q   <= 1'b0;
            aw_addr_q  <= 12'h000;
            w_data_q   <= 32'h0000_0000;
            w_strb_q   <= 4'h0;
            bvalid_q   <= 1'b0;
            bresp_q    <= 2'b00;
            rvalid_q   <= 1'b0;
            rdata_q    <= 32'h0000_0000;
            rresp_q    <= 2'b00;
            op_on_q    <= `SOT_RST_OP;
            thresh_q   <= `SOT_RST_THRESH_PCT;
            delay_q    <= `SOT_RST_DELAY_MS;
            irq_stat_q <= 2'b00;
            irq_en_q   <= 2'b00;
            irq        <= 1'b0;
            awready_q  <= 1'b1;
            wready_q   <= 1'b1;
            arready_q  <= 1'b1;
        end
        else
        begin
            aw_have_q  <= aw_have_d;
            w_have_q   <= w_have_d;
            aw_addr_q  <= aw_addr_d;
            w_data_q   <= w_data_d;
            w_strb_q   <= w_strb_d;
            bvalid_q   <= bvalid_d;
            bresp_q    <= bresp_d;
            rvalid_q   <= rvalid_d;
            rdata_q    <= rdata_d;
            rresp_q    <= rresp_d;
            op_on_q    <= op_on_d;
            thresh_q   <= thresh_d;
            delay_q    <= delay_d;
            irq_stat_q <= irq_stat_d;
            irq_en_q   <= irq_en_d;
            irq        <= |(irq_stat_d & irq_en_d);
            awready_q  <= awready_d;
            wready_q   <= wready_d;
            arready_q  <= arready_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

endmodule : sotrip_top
`default_nettype wire

// file: verif/sotrip_checker.sv
// assertion checker for the stub overcurrent trip block
`timescale 1ns/1ps
`default_nettype none
module sotrip_checker #(
    parameter int MAG_W      = 16,
    parameter int CYC_PER_MS = 20000
)(
    input wire logic             aclk,
    input wire logic             aresetn,
    input wire logic [MAG_W-1:0] phase1_mag,
    input wire logic [MAG_W-1:0] phase2_mag,
    input wire logic [MAG_W-1:0] phase3_mag,
    input wire logic             function_disable_in,
    input wire logic             breaker_open_in,
    input wire logic             phase1_start_flag,
    input wire logic             phase2_start_flag,
    input wire logic             phase3_start_flag,
    input wire logic             any_phase_start,
    input wire logic             stub_trip_out,
    input wire logic             s_axi_bvalid,
    input wire logic             s_axi_bready,
    input wire logic             s_axi_rvalid,
    input wire logic             s_axi_rready
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // pins held long enough to pass the synchroniser
    sequence s_disabled;
        function_disable_in [*5];
    endsequence
    sequence s_closed;
        !breaker_open_in [*5];
    endsequence
    property p_no_current;
        (phase1_mag == '0 |=> !phase1_start_flag) and (phase2_mag == '0 |=> !phase2_start_flag)
            and (phase3_mag == '0 |=> !phase3_start_flag);
    endproperty

    a_general_or: assert property (any_phase_start ==
        (phase1_start_flag | phase2_start_flag | phase3_start_flag)) else $error("general start");
    a_no_current: assert property (p_no_current)
        else $error("start without current");
    a_trip_needs_start: assert property (stub_trip_out |-> any_phase_start)
        else $error("trip without start");
    a_trip_after_start: assert property ($rose(stub_trip_out)
        |-> any_phase_start && $past(breaker_open_in, 3)) else $error("trip without open breaker");
    a_disable_quiet: assert property (s_disabled |-> !any_phase_start && !stub_trip_out)
        else $error("output while disabled");
    a_closed_no_trip: assert property (s_closed |-> !stub_trip_out)
        else $error("trip while breaker closed");
    a_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_rdata_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response repeated");
endmodule : sotrip_checker

bind sotrip_top sotrip_checker #(.MAG_W(MAG_W), .CYC_PER_MS(CYC_PER_MS)) i_sotrip_checker (
    .aclk(aclk), .aresetn(aresetn), .phase1_mag(phase1_mag), .phase2_mag(phase2_mag),
    .phase3_mag(phase3_mag), .function_disable_in(function_disable_in),
    .breaker_open_in(breaker_open_in), .phase1_start_flag(phase1_start_flag),
    .phase2_start_flag(phase2_start_flag), .phase3_start_flag(phase3_start_flag),
    .any_phase_start(any_phase_start), .stub_trip_out(stub_trip_out),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

// file: verif/sotrip_partner.sv
// current front end and breaker model for the stub overcurrent trip block
`timescale 1ns/1ps
`default_nettype none
module sotrip_partner #(
    parameter int NOM_MAG = 1000
)(
    input  wire logic        aclk,
    input  wire logic [9:0]  pct [3],
    input  wire logic        cb_open,
    input  wire logic        stub_trip_out,
    output logic      [15:0] m [3],
    output logic      [15:0] nominal_mag,
    output logic             breaker_open_in,
    output int               trip_count
);
    logic trip_q;

    // quiet line, closed breaker, no trips at time zero
    initial
    begin
        m               = '{default: '0};
        breaker_open_in = 1'b0;
        trip_count      = 0;
        trip_q          = 1'b0;
    end
    assign nominal_mag = 16'(NOM_MAG);

    // fundamental magnitudes as percent of nominal, status of the breaker
    always @(posedge aclk)
    begin
        foreach (m[i]) m[i] <= 16'(pct[i] * NOM_MAG / 100);
        breaker_open_in <= cb_open;
        trip_q          <= stub_trip_out;
        if (stub_trip_out && !trip_q)
            trip_count <= trip_count + 1;
    end
endmodule : sotrip_partner
`default_nettype wire

// file: verif/tb_stub_overcurrent_trip.sv
// self-checking bench for the stub overcurrent trip block
`timescale 1ns/1ps
`default_nettype none
`include "sotrip_defs.svh"
module tb_stub_overcurrent_trip;
    import sotrip_pkg::*;
    localparam int CPM = 4;
    logic        aclk = 1'b0, aresetn = 1'b0, cb_open = 1'b0, function_disable_in = 1'b0;
    logic [9:0]  pct [3] = '{default: '0};
    logic [15:0] m [3];
    logic [15:0] nom;
    logic        breaker_open_in, f1, f2, f3, any_st, trip, irq;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [3:0]  flags;
    int          trip_count, n_fail = 0, comparisons = 0;
    assign flags = {any_st, f3, f2, f1};

    always #25 aclk = ~aclk;

    sotrip_top #(.MAG_W(16), .CYC_PER_MS(CPM)) i_sotrip_top (
        .aclk(aclk), .aresetn(aresetn), .phase1_mag(m[0]), .phase2_mag(m[1]), .phase3_mag(m[2]),
        .nominal_mag(nom), .function_disable_in(function_disable_in),
        .breaker_open_in(breaker_open_in), .phase1_start_flag(f1), .phase2_start_flag(f2),
        .phase3_start_flag(f3), .any_phase_start(any_st), .stub_trip_out(trip), .irq(irq),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    sotrip_partner i_sotrip_partner (.aclk(aclk), .pct(pct), .cb_open(cb_open),
        .stub_trip_out(trip), .m(m), .nominal_mag(nom), .breaker_open_in(breaker_open_in),
        .trip_count(trip_count));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask : tick

    task automatic fault(input logic [9:0] p, input logic o);
        foreach (pct[i]) pct[i] <= p;
        cb_open <= o;
    endtask : fault

    // bus write: address and data offered together, each released when taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_open;
        logic w_open;
        @(posedge aclk);
        aw_open = 1'b1;
        w_open  = 1'b1;
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (aw_open || w_open)
        begin
            @(posedge aclk);
            if (aw_open && awready)
            begin
                aw_open = 1'b0;
                awvalid <= 1'b0;
            end
            if (w_open && wready)
            begin
                w_open = 1'b0;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        bready <= 1'b0;
        chk("bresp", 32'(er), 32'(bresp));
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'b0;
        chk("rdata", ed, rdata);
        chk("rresp", 32'(er), 32'(rresp));
    endtask : rd

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_defaults;
        rd(`SOT_OFS_CTRL, 32'h0, 2'b00);
        rd(`SOT_OFS_THRESH, 32'h32, 2'b00);
        rd(`SOT_OFS_DELAY, 32'h64, 2'b00);
        rd(12'h100, 32'h0, SOT_AXI_RESP_SLVERR);
        fault(10'h0c8, 1'b1);
        tick(12);
        chk("starts_off", 32'h0, 32'(flags));
        chk("trip_off", 32'h0, 32'(trip));
        fault(10'h0, 1'b0);
    endtask : t_defaults

    task automatic t_limits;
        logic [11:0] a [7] = '{12'h004, 12'h004, 12'h004, 12'h004, 12'h008, 12'h008, 12'h01c};
        logic [31:0] d [7] = '{32'd9, 32'd401, 32'd10, 32'd400, 32'd60001, 32'd60000, 32'h1};
        logic [1:0]  r [7] = '{2'b10, 2'b10, 2'b00, 2'b00, 2'b10, 2'b00, 2'b10};
        for (int i = 0; i < 7; i++)
            wr(a[i], d[i], r[i]);
        rd(`SOT_OFS_THRESH, 32'd400, 2'b00);
        rd(`SOT_OFS_DELAY, 32'd60000, 2'b00);
        wr(`SOT_OFS_THRESH, 32'd50, 2'b00);
    endtask : t_limits

    task automatic t_threshold;
        wr(`SOT_OFS_CTRL, 32'h1, 2'b00);
        for (int p = 0; p < 3; p++)
        begin
            for (int k = 0; k < 2; k++)
            begin
                pct[p] <= 10'(50 + k);
                tick(6);
                chk("starts", k ? 32'h8 | (32'h1 << p) : 32'h0, 32'(flags));
            end
            pct[p] <= 10'h0;
        end
        tick(6);
    endtask : t_threshold

    task automatic t_trip(input int dly);
        int n;
        wr(`SOT_OFS_DELAY, 32'(dly), 2'b00);
        fault(10'h0, 1'b1);
        tick(6);
        fault(10'h0c8, 1'b1);
        do @(posedge aclk); while (!any_st);
        n = 0;
        while (!trip)
        begin
            @(posedge aclk);
            n++;
        end
        chk("trip_window", 32'h1, 32'(n >= dly * CPM && n <= dly * CPM + 1));
        rd(`SOT_OFS_STATUS, 32'h1f, 2'b00);
        cb_open <= 1'b0;
        tick(6);
        chk("trip_drop", 32'h0, 32'(trip));
        chk("starts_hold", 32'hf, 32'(flags));
        fault(10'h0, 1'b0);
        tick(6);
    endtask : t_trip

    task automatic t_irq;
        rd(`SOT_OFS_IRQ_STAT, 32'h3, 2'b00);
        wr(`SOT_OFS_IRQ_EN, 32'h2, 2'b00);
        tick(2);
        chk("irq_on", 32'h1, 32'(irq));
        wr(`SOT_OFS_IRQ_EN, 32'h0, 2'b00);
        tick(2);
        chk("irq_masked", 32'h0, 32'(irq));
        wr(`SOT_OFS_IRQ_EN, 32'h2, 2'b00);
        wr(`SOT_OFS_IRQ_CLR, 32'h3, 2'b00);
        tick(2);
        chk("irq_cleared", 32'h0, 32'(irq));
        rd(`SOT_OFS_IRQ_STAT, 32'h0, 2'b00);
    endtask : t_irq

    task automatic t_abort;
        int c0;
        c0 = trip_count;
        fault(10'h0, 1'b1);
        tick(6);
        fault(10'h0c8, 1'b1);
        do @(posedge aclk); while (!any_st);
        tick(2);
        cb_open <= 1'b0;
        tick(6 * CPM);
        chk("trip_count", 32'(c0), 32'(trip_count));
        fault(10'h0, 1'b0);
        tick(6);
        chk("starts_gone", 32'h0, 32'(flags));
    endtask : t_abort

    task automatic t_disable;
        function_disable_in <= 1'b1;
        fault(10'h0c8, 1'b1);
        tick(6 * CPM);
        chk("starts_dis", 32'h0, 32'(flags));
        chk("trip_dis", 32'h0, 32'(trip));
        rd(`SOT_OFS_STATUS, 32'h30, 2'b00);
        function_disable_in <= 1'b0;
        tick(6);
        chk("starts_back", 32'hf, 32'(flags));
        fault(10'h0, 1'b0);
    endtask : t_disable

    // main sequence after reset
    initial
    begin
        tick(6);
        aresetn <= 1'b1;
        t_defaults;
        t_limits;
        t_threshold;
        t_trip(0);
        t_trip(2);
        t_irq;
        t_abort;
        t_disable;
        stop_test;
    end

    // watchdog against a hung handshake
    initial
    begin
        tick(20000);
        n_fail++;
        stop_test;
    end
endmodule : tb_stub_overcurrent_trip
`default_nettype wire
